// *** ibc_pkg.sv ***
// Package with register map, field positions and constants of the bus collision master.
package ibc_pkg;
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_BUF    = 8'h08;
   localparam logic [7:0] ADDR_RELOAD = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CL = 8'h14;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
   // Sequence control register bits.
   localparam int CTL_START   = 0;
   localparam int CTL_RESTART = 1;
   localparam int CTL_STOP    = 2;
   localparam int CTL_ACK     = 4;
   localparam int CTL_ACKDT   = 5;
   localparam int CTL_ENABLE  = 7;
   // Status bits.
   localparam int ST_BF    = 0;
   localparam int ST_START = 3;
   localparam int ST_STOP  = 4;
   localparam int ST_IDLE  = 5;
   // Interrupt bits: collision and port event.
   localparam int IRQ_COLL  = 0;
   localparam int IRQ_EVENT = 1;
   localparam logic [6:0] RELOAD_RST = 7'h04;
   localparam logic [7:0] CTRL_RST   = 8'h00;
endpackage

// *** ibc_master.sv ***
// Bus collision aware serial master port with APB registers.
module ibc_master
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   output logic             irq
);
   typedef enum logic [10:0] {
      S_IDLE  = 11'h001,
      S_ST1   = 11'h002,
      S_ST2   = 11'h004,
      S_RS1   = 11'h008,
      S_RS2   = 11'h010,
      S_RS3   = 11'h020,
      S_SP1   = 11'h040,
      S_SP2   = 11'h080,
      S_SP3   = 11'h100,
      S_BIT   = 11'h200,
      S_ACK   = 11'h400
   } ibc_state_t;

   typedef struct packed {
      ibc_state_t  st;
      logic [6:0]  cnt;
      logic        cnt_run;
      logic [2:0]  sda_s;
      logic [2:0]  scl_s;
      logic        sda_f;
      logic        scl_f;
      logic        sda_lo;
      logic        scl_lo;
      logic [7:0]  ctrl;
      logic [6:0]  reload;
      logic [7:0]  buf_q;
      logic [7:0]  shft;
      logic [3:0]  bitn;
      logic        phase;
      logic        bf;
      logic        sflag;
      logic        pflag;
      logic [1:0]  ist;
      logic [1:0]  ien;
      logic [31:0] rdata;
      logic        rdy;
      logic        irq;
   } ibc_regs_t;

   ibc_regs_t r, n;
   logic sda, scl, wr, rd, cnt_done, coll, ev_stop, ev_start;

   always_comb
   begin
      n = r;
      // Three stage sampling; a level changes once stages two and three agree.
      n.sda_s = {r.sda_s[1:0], sda_i};
      n.scl_s = {r.scl_s[1:0], scl_i};
      if (r.sda_s[1] == r.sda_s[2]) n.sda_f = r.sda_s[2];
      if (r.scl_s[1] == r.scl_s[2]) n.scl_f = r.scl_s[2];
      sda = r.sda_f;
      scl = r.scl_f;
      // Bus conditions seen from the filtered levels.
      ev_start = scl && r.sda_f && (r.sda_s[1] == r.sda_s[2]) && !r.sda_s[2];
      ev_stop  = scl && !r.sda_f && (r.sda_s[1] == r.sda_s[2]) && r.sda_s[2];
      wr = psel && penable && pwrite && !r.rdy;
      rd = psel && penable && !pwrite && !r.rdy;
      n.rdy = psel && penable && !r.rdy;
      cnt_done = r.cnt_run && (r.cnt == 7'h00);
      if (r.cnt_run && r.cnt != 7'h00) n.cnt = r.cnt - 7'h01;
      coll = 1'b0;
      // Counter loads take effect next cycle; a load in S_IDLE, S_RS1 or S_SP1 marks the count running.
      unique case (r.st)
         S_IDLE:
         begin
            n.cnt_run = 1'b0;
            n.sda_lo = 1'b0;
            n.scl_lo = r.scl_lo;
            if (r.ctrl[ibc_pkg::CTL_START])
            begin
               n.scl_lo = 1'b0;
               if (!sda || !scl) coll = 1'b1;
               else
               begin
                  n.cnt = r.reload;
                  n.cnt_run = 1'b1;
                  n.st = S_ST1;
               end
            end
            else if (r.ctrl[ibc_pkg::CTL_RESTART])
            begin
               n.scl_lo = 1'b1;
               n.cnt = r.reload;
               n.cnt_run = 1'b1;
               n.st = S_RS1;
            end
            else if (r.ctrl[ibc_pkg::CTL_STOP])
            begin
               n.sda_lo = 1'b1;
               n.scl_lo = 1'b1;
               n.cnt_run = 1'b0;
               n.st = S_SP1;
            end
            else if (r.ctrl[ibc_pkg::CTL_ACK])
            begin
               n.scl_lo = 1'b1;
               n.sda_lo = !r.ctrl[ibc_pkg::CTL_ACKDT];
               n.cnt = r.reload;
               n.cnt_run = 1'b1;
               n.phase = 1'b0;
               n.st = S_ACK;
            end
            else if (r.bf)
            begin
               n.shft = r.buf_q;
               n.bitn = 4'h0;
               n.phase = 1'b0;
               n.scl_lo = 1'b1;
               n.cnt = r.reload;
               n.cnt_run = 1'b1;
               n.st = S_BIT;
            end
         end
         S_ST1:
         begin
            if (!sda)
            begin
               n.sda_lo = 1'b1;
               n.cnt = r.reload;
               n.st = S_ST2;
            end
            else if (!scl) coll = 1'b1;
            else if (cnt_done)
            begin
               n.sda_lo = 1'b1;
               n.cnt = r.reload;
               n.st = S_ST2;
            end
         end
         S_ST2:
         begin
            if (cnt_done)
            begin
               n.scl_lo = 1'b1;
               n.cnt_run = 1'b0;
               n.ctrl[ibc_pkg::CTL_START] = 1'b0;
               n.st = S_IDLE;
            end
         end
         S_RS1:
         begin
            if (cnt_done)
            begin
               n.scl_lo = 1'b0;
               n.cnt_run = 1'b0;
            end
            if (!r.cnt_run && scl)
            begin
               if (!sda) coll = 1'b1;
               else
               begin
                  n.cnt = r.reload;
                  n.cnt_run = 1'b1;
                  n.st = S_RS2;
               end
            end
         end
         S_RS2:
         begin
            if (!scl && sda) coll = 1'b1;
            else if (cnt_done || !sda)
            begin
               n.sda_lo = 1'b1;
               n.cnt = r.reload;
               n.st = S_RS3;
            end
         end
         S_RS3:
         begin
            if (cnt_done)
            begin
               n.scl_lo = 1'b1;
               n.cnt_run = 1'b0;
               n.ctrl[ibc_pkg::CTL_RESTART] = 1'b0;
               n.st = S_IDLE;
            end
         end
         S_SP1:
         begin
            if (!sda && !r.cnt_run)
            begin
               n.scl_lo = 1'b0;
               n.cnt_run = 1'b1;
               n.cnt = r.reload;
            end
            if (r.cnt_run && !r.scl_lo && scl)
            begin
               n.cnt = r.reload;
               n.st = S_SP2;
            end
         end
         S_SP2:
         begin
            if (!scl) coll = 1'b1;
            else if (cnt_done)
            begin
               n.sda_lo = 1'b0;
               n.cnt = r.reload;
               n.st = S_SP3;
            end
         end
         S_SP3:
         begin
            if (cnt_done)
            begin
               if (!sda) coll = 1'b1;
               else
               begin
                  n.cnt_run = 1'b0;
                  n.ctrl[ibc_pkg::CTL_STOP] = 1'b0;
                  n.ist[ibc_pkg::IRQ_EVENT] = 1'b1;
                  n.st = S_IDLE;
               end
            end
         end
         S_BIT, S_ACK:
         begin
            // Phase 0 holds SCL low with data set, phase 1 releases SCL high.
            if (r.st == S_BIT && r.phase == 1'b0)
               n.sda_lo = (r.bitn < 4'h8) ? !r.shft[7] : 1'b0;
            if (r.phase && scl && !r.sda_lo && !sda
                && (r.st == S_ACK || r.bitn < 4'h8)) coll = 1'b1;
            else if (cnt_done)
            begin
               n.cnt = r.reload;
               n.phase = !r.phase;
               n.scl_lo = r.phase;
               if (r.phase && r.st == S_BIT)
               begin
                  n.shft = {r.shft[6:0], 1'b0};
                  n.bitn = r.bitn + 4'h1;
                  if (r.bitn == 4'h7) n.bf = 1'b0;
                  if (r.bitn == 4'h8)
                  begin
                     n.ist[ibc_pkg::IRQ_EVENT] = 1'b1;
                     n.cnt_run = 1'b0;
                     n.sda_lo = 1'b0;
                     n.st = S_IDLE;
                  end
               end
               else if (r.phase)
               begin
                  n.ctrl[ibc_pkg::CTL_ACK] = 1'b0;
                  n.cnt_run = 1'b0;
                  n.sda_lo = 1'b0;
                  n.st = S_IDLE;
               end
            end
         end
      endcase
      if (coll)
      begin
         n.ist[ibc_pkg::IRQ_COLL] = 1'b1;
         n.sda_lo = 1'b0;
         n.scl_lo = 1'b0;
         n.bf = 1'b0;
         n.cnt_run = 1'b0;
         n.ctrl[4:0] = 5'h00;
         n.st = S_IDLE;
      end
      // Bus watching continues in every state, collision or not.
      if (ev_start) n.sflag = 1'b1;
      if (ev_stop)
      begin
         n.pflag = 1'b1;
         n.sflag = 1'b0;
         n.ist[ibc_pkg::IRQ_EVENT] = 1'b1;
      end
      if (ev_start) n.pflag = 1'b0;
      if (!r.ctrl[ibc_pkg::CTL_ENABLE])
      begin
         n.sflag = 1'b0;
         n.pflag = 1'b0;
         n.st = S_IDLE;
         n.sda_lo = 1'b0;
         n.scl_lo = 1'b0;
         n.cnt_run = 1'b0;
      end
      if (wr)
      begin
         unique case (paddr)
            ibc_pkg::ADDR_CTRL:   n.ctrl = pwdata[7:0] | (n.ctrl & 8'h1f);
            ibc_pkg::ADDR_RELOAD: n.reload = pwdata[6:0];
            ibc_pkg::ADDR_IRQ_EN: n.ien = pwdata[1:0];
            // Set beats clear: only bits not being set this cycle are cleared.
            ibc_pkg::ADDR_IRQ_CL: n.ist = n.ist & ~(pwdata[1:0] & ~(n.ist & ~r.ist));
            ibc_pkg::ADDR_BUF:
            begin
               if (r.st == S_IDLE)
               begin
                  n.buf_q = pwdata[7:0];
                  n.bf = 1'b1;
               end
            end
            default: n.rdy = n.rdy;
         endcase
      end
      n.rdata = 32'h0000_0000;
      if (rd)
      begin
         unique case (paddr)
            ibc_pkg::ADDR_CTRL:   n.rdata = {24'h000000, r.ctrl};
            ibc_pkg::ADDR_RELOAD: n.rdata = {25'h0000000, r.reload};
            ibc_pkg::ADDR_BUF:    n.rdata = {24'h000000, r.buf_q};
            ibc_pkg::ADDR_IRQ_ST: n.rdata = {30'h00000000, r.ist};
            ibc_pkg::ADDR_IRQ_EN: n.rdata = {30'h00000000, r.ien};
            ibc_pkg::ADDR_STATUS: n.rdata = {26'h0000000, (r.st == S_IDLE), r.pflag,
                                             r.sflag, 2'h0, r.bf};
            default:              n.rdata = 32'h0000_0000;
         endcase
      end
      n.irq = |(n.ist & n.ien);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r        <= '0;
         r.st     <= S_IDLE;
         r.sda_s  <= 3'h7;
         r.scl_s  <= 3'h7;
         r.sda_f  <= 1'b1;
         r.scl_f  <= 1'b1;
         r.ctrl   <= ibc_pkg::CTRL_RST;
         r.reload <= ibc_pkg::RELOAD_RST;
      end
      else
         r <= n;
   end

   assign prdata  = r.rdata;
   assign pready  = r.rdy;
   assign pslverr = 1'b0;
   assign sda_o   = 1'b0;
   assign scl_o   = 1'b0;
   assign sda_oe  = r.sda_lo;
   assign scl_oe  = r.scl_lo;
   assign irq     = r.irq;
endmodule

// *** ibc_master_sva.sv ***
// Checker of port relations of the collision aware master.
module ibc_chk
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe,
   input wire logic        scl_i,
   input wire logic        scl_o,
   input wire logic        scl_oe,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_clr;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Only a clear or an enable write may take the interrupt down.
   assign wr_clr = psel && penable && pwrite
                   && (paddr == ibc_pkg::ADDR_IRQ_CL || paddr == ibc_pkg::ADDR_IRQ_EN);
   sequence sda_first;
      $rose(sda_oe) && !scl_oe;
   endsequence
   sequence scl_follow;
      ##[1:300] $rose(scl_oe);
   endsequence
   a_ready_follows: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_no_slverr: assert property (pslverr == 1'b0)
      else $error("slave error raised");
   a_open_drain: assert property (sda_o == 1'b0 && scl_o == 1'b0)
      else $error("line driven high");
   a_irq_sticky: assert property ($fell(irq) |-> $past(wr_clr) || $past(wr_clr, 2))
      else $error("interrupt dropped without clear");
   a_start_hold: assert property (sda_first |-> sda_oe throughout scl_follow)
      else $error("clock not pulled low after data");
endmodule
bind ibc_master ibc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .irq(irq));

// *** ibc_bus_model.sv ***
// Far side of the bus: pull-ups and a second master that can pull lines or clock.
module ibc_bus_model
(
   input  wire logic sda_oe,
   input  wire logic scl_oe,
   input  wire logic peer_sda_low,
   input  wire logic peer_run,
   output logic      sda,
   output logic      scl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic peer_clk = 1'b1;
   // The peer clock stands high outside its frames, as a real master would leave it.
   always #160 peer_clk = peer_run ? !peer_clk : 1'b1;
   // Wired-AND with pull-ups, so a released line never shows a stale value.
   assign sda = !(sda_oe || peer_sda_low);
   assign scl = !(scl_oe || !peer_clk);
endmodule

// *** ibc_tb.sv ***
// Self-checking bench of the collision aware master.
`define CHK(nm, ex, got) \
   begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, m, e;} ibc_row_t;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, sda_o, sda_oe, scl_o, scl_oe, irq, sda, scl;
   logic peer_sda_low = 1'b0, peer_run = 1'b0;
   int miscompares = 0, comparisons = 0, cycles = 0;
   ibc_row_t rows [14] = '{
      '{0, ibc_pkg::ADDR_CTRL, 0, 32'hff, 0}, '{0, ibc_pkg::ADDR_RELOAD, 0, 32'h7f, 4},
      '{0, ibc_pkg::ADDR_IRQ_ST, 0, 32'h3, 0}, '{0, ibc_pkg::ADDR_IRQ_EN, 0, 32'h3, 0},
      '{0, ibc_pkg::ADDR_STATUS, 0, 32'h18, 0}, '{1, ibc_pkg::ADDR_RELOAD, 32'hff, 0, 0},
      '{0, ibc_pkg::ADDR_RELOAD, 0, 32'hffffffff, 32'h7f},
      '{1, ibc_pkg::ADDR_RELOAD, 8, 0, 0}, '{1, ibc_pkg::ADDR_IRQ_EN, 3, 0, 0},
      '{0, ibc_pkg::ADDR_IRQ_EN, 0, 32'hffffffff, 3}, '{1, ibc_pkg::ADDR_IRQ_ST, 3, 0, 0},
      '{0, ibc_pkg::ADDR_IRQ_ST, 0, 32'hffffffff, 0}, '{1, 8'h1c, 32'hffffffff, 0, 0},
      '{0, 8'h1c, 0, 32'hffffffff, 0}};
   always #20 pclk = !pclk;
   ibc_master uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl),
      .scl_o(scl_o), .scl_oe(scl_oe), .irq(irq));
   ibc_bus_model peer (.sda_oe(sda_oe), .scl_oe(scl_oe), .peer_sda_low(peer_sda_low),
      .peer_run(peer_run), .sda(sda), .scl(scl));
   task automatic report_and_stop();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Polls a register until the masked value appears, giving up after 200 reads.
   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      do
      begin
         apb(1'b0, a, 32'h0);
         n++;
      end
      while ((rd & m) !== v && n < 200);
      `CHK("poll", v, rd & m)
   endtask
   initial
   begin
      int n;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w)
            `CHK("register", rows[i].e, rd & rows[i].m)
      end
      $display("test table done");
      peer_sda_low <= 1'b1;
      // Let the low level clear the input filter, so the start sees it already low.
      repeat (8) @(posedge pclk);
      apb(1'b1, ibc_pkg::ADDR_CTRL, 32'h81);
      poll(ibc_pkg::ADDR_IRQ_ST, 32'h1, 32'h1);
      apb(1'b0, ibc_pkg::ADDR_CTRL, 32'h0);
      `CHK("start bit", 1'b0, rd[ibc_pkg::CTL_START])
      `CHK("lines", 2'b00, {sda_oe, scl_oe})
      `CHK("irq", 1'b1, irq)
      peer_sda_low <= 1'b0;
      poll(ibc_pkg::ADDR_STATUS, 32'h10, 32'h10);
      $display("test start abort done");
      apb(1'b1, ibc_pkg::ADDR_CTRL, 32'h81);
      poll(ibc_pkg::ADDR_CTRL, 32'h1, 32'h0);
      `CHK("lines", 2'b01, {sda_oe, scl_oe})
      apb(1'b0, ibc_pkg::ADDR_IRQ_ST, 32'h0);
      `CHK("sticky", 1'b1, rd[ibc_pkg::IRQ_COLL])
      apb(1'b1, ibc_pkg::ADDR_IRQ_CL, 32'h3);
      poll(ibc_pkg::ADDR_IRQ_ST, 32'h3, 32'h0);
      `CHK("irq", 1'b0, irq)
      $display("test sticky done");
      apb(1'b1, ibc_pkg::ADDR_BUF, 32'hff);
      peer_sda_low <= 1'b1;
      poll(ibc_pkg::ADDR_IRQ_ST, 32'h1, 32'h1);
      apb(1'b0, ibc_pkg::ADDR_STATUS, 32'h0);
      `CHK("buffer full", 1'b0, rd[ibc_pkg::ST_BF])
      `CHK("lines", 2'b00, {sda_oe, scl_oe})
      peer_run <= 1'b1;
      repeat (32) @(posedge pclk);
      peer_run <= 1'b0;
      repeat (8) @(posedge pclk);
      peer_sda_low <= 1'b0;
      poll(ibc_pkg::ADDR_IRQ_ST, 32'h2, 32'h2);
      poll(ibc_pkg::ADDR_STATUS, 32'h10, 32'h10);
      $display("test byte collision done");
      apb(1'b1, ibc_pkg::ADDR_IRQ_CL, 32'h3);
      apb(1'b1, ibc_pkg::ADDR_CTRL, 32'h81);
      poll(ibc_pkg::ADDR_CTRL, 32'h1, 32'h0);
      apb(1'b1, ibc_pkg::ADDR_BUF, 32'h7f);
      n = 0;
      while (scl_oe !== 1'b0 && n < 500)
      begin
         @(posedge pclk);
         n++;
      end
      `CHK("first bit", 1'b1, sda_oe)
      poll(ibc_pkg::ADDR_STATUS, 32'h1, 32'h0);
      apb(1'b1, ibc_pkg::ADDR_CTRL, 32'h84);
      poll(ibc_pkg::ADDR_CTRL, 32'h4, 32'h0);
      `CHK("lines", 2'b00, {sda_oe, scl_oe})
      poll(ibc_pkg::ADDR_IRQ_ST, 32'h1, 32'h0);
      $display("test resend done");
      apb(1'b1, ibc_pkg::ADDR_CTRL, 32'h0);
      poll(ibc_pkg::ADDR_STATUS, 32'h18, 32'h0);
      $display("test disable done");
      report_and_stop();
   end
endmodule
